// *** verilog/fls_defines.vh ***
// Offsets, field positions, opcodes and reset values of the executor
`ifndef FLS_DEFINES_VH
`define FLS_DEFINES_VH

// Wishbone byte offsets
`define FLS_CMD_OFS        8'h00
`define FLS_OPERAND_OFS    8'h04
`define FLS_FLAGS_OFS      8'h08
`define FLS_STATUS_OFS     8'h0C
`define FLS_GPR_BASE       8'h80
`define FLS_GPR_MASK       8'h7C

// Command register fields
`define FLS_CMD_OP_LSB     0
`define FLS_CMD_OP_MSB     5
`define FLS_CMD_RD_LSB     8
`define FLS_CMD_RD_MSB     12
`define FLS_CMD_RR_LSB     16
`define FLS_CMD_RR_MSB     20

// Status register bits
`define FLS_STAT_BUSY      0
`define FLS_STAT_ILLEGAL   1

// Processor flag bit positions
`define FLS_FLAG_C         3'h0
`define FLS_FLAG_Z         3'h1
`define FLS_FLAG_N         3'h2
`define FLS_FLAG_V         3'h3
`define FLS_FLAG_S         3'h4
`define FLS_FLAG_H         3'h5
`define FLS_FLAG_T         3'h6
`define FLS_FLAG_I         3'h7

// Opcodes, group 00: plain transfers
`define FLS_NOP_OP                   6'h00
`define FLS_REGISTER_COPY_OP         6'h01
`define FLS_REGISTER_PAIR_COPY_OP    6'h02
`define FLS_IMMEDIATE_LOAD_OP        6'h03
`define FLS_DIRECT_DATA_LOAD_OP      6'h04
// Group 01: flag ops, bit 3 set means drop, bits 2:0 the flag
`define FLS_FLAG_GROUP               2'h1
`define FLS_CARRY_FLAG_CLEAR_OP      6'h18
`define FLS_NEGATIVE_FLAG_RAISE_OP   6'h12
`define FLS_NEGATIVE_FLAG_DROP_OP    6'h1A
`define FLS_ZERO_FLAG_RAISE_OP       6'h11
`define FLS_ZERO_FLAG_DROP_OP        6'h19
`define FLS_INTERRUPTS_ON_OP         6'h17
`define FLS_INTERRUPTS_OFF_OP        6'h1F
`define FLS_SIGN_FLAG_RAISE_OP       6'h14
`define FLS_SIGN_FLAG_DROP_OP        6'h1C
`define FLS_OVERFLOW_RAISE_OP        6'h13
`define FLS_OVERFLOW_DROP_OP         6'h1B
`define FLS_TRANSFER_BIT_DROP_OP     6'h1E
`define FLS_HALF_CARRY_RAISE_OP      6'h15
`define FLS_HALF_CARRY_DROP_OP       6'h1D
// Group 1x: pointer ops {1, store, ptr[1:0], mode[1:0]}
`define FLS_MODE_PLAIN     2'h0
`define FLS_MODE_POSTINC   2'h1
`define FLS_MODE_PREDEC    2'h2
`define FLS_MODE_DISP      2'h3
`define FLS_PTR_FIRST      2'h0
`define FLS_PTR_NONE       2'h3
// Pair index of the first pointer pair (registers 26:27)
`define FLS_PTR_PAIR_BASE  4'hD

// Reset values
`define FLS_FLAGS_RST      8'h00
`define FLS_GPR_RST        8'h00

`endif

// *** verilog/fls_regfile.v ***
// General-purpose register file: byte and register-pair ports
`default_nettype none

module fls_regfile #(
	parameter NREG = 32,
	parameter AW   = 5
) (
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire [AW-1:0] rd_b_idx_i,
	output wire [7:0]    rd_b_o,
	input  wire [AW-2:0] rd_w_idx_i,
	output wire [15:0]   rd_w_o,
	input  wire          wr_b_we_i,
	input  wire [AW-1:0] wr_b_idx_i,
	input  wire [7:0]    wr_b_data_i,
	input  wire          wr_w_we_i,
	input  wire [AW-2:0] wr_w_idx_i,
	input  wire [15:0]   wr_w_data_i
);
`include "fls_defines.vh"

	reg [7:0] mem_r [0:NREG-1];

	assign rd_b_o = mem_r[rd_b_idx_i];
	assign rd_w_o = {mem_r[{rd_w_idx_i, 1'b1}], mem_r[{rd_w_idx_i, 1'b0}]};

	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			localparam [AW-1:0] IDX = g;
			// Byte write wins over a pair write to the same register
			always @(posedge clk_i) begin
				if (rst_i) begin
					mem_r[g] <= `FLS_GPR_RST;
				end else if (wr_b_we_i && wr_b_idx_i == IDX) begin
					mem_r[g] <= wr_b_data_i;
				end else if (wr_w_we_i && wr_w_idx_i == IDX[AW-1:1]) begin
					mem_r[g] <= IDX[0] ? wr_w_data_i[15:8] : wr_w_data_i[7:0];
				end
			end
		end
	endgenerate

endmodule // fls_regfile
`default_nettype wire

// *** verilog/fls_flags.v ***
// Processor flags register with single-bit set and clear
`default_nettype none

module fls_flags (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       bit_we_i,
	input  wire [2:0] bit_idx_i,
	input  wire       bit_val_i,
	input  wire       sw_we_i,
	input  wire [7:0] sw_data_i,
	output reg  [7:0] flags_o
);
`include "fls_defines.vh"

	reg [7:0] flags_nxt;

	// A bit write moves only the addressed bit; a software write loads all eight bits
	always @* begin
		flags_nxt = flags_o;
		if (sw_we_i) begin
			flags_nxt = sw_data_i;
		end
		if (bit_we_i) begin
			flags_nxt[bit_idx_i] = bit_val_i;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			flags_o <= `FLS_FLAGS_RST;
		end else begin
			flags_o <= flags_nxt;
		end
	end

endmodule // fls_flags
`default_nettype wire

// *** verilog/fls_exec.v ***
// Flag and load/store executor with Wishbone register access
//
// The address map and the Wishbone register port were chosen for this implementation.
`default_nettype none

//
// Operation
// - Overflow raise/drop: one cycle, only V
// - Half-carry raise/drop: one cycle, only H
// - Sign raise/drop: one cycle, only S
// - First pointer post-increment load: read, then +1
// - First pointer pre-decrement load: -1, then read
// - Second pointer plain, post-inc, pre-dec loads
// - Third pointer plain, post-inc, pre-dec loads
// - Displacement load on second/third, pointer kept
// - Direct load from instruction address, two cycles
// - Post-increment store: write, then pointer +1
// - Pre-decrement store: pointer -1, then write
module fls_exec #(
	parameter ADR_W = 8,
	parameter DAW   = 16
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [ADR_W-1:0] wb_adr_i,
	input  wire [3:0]       wb_sel_i,
	input  wire [31:0]      wb_dat_i,
	output reg  [31:0]      wb_dat_o,
	output reg              wb_ack_o,
	output reg  [DAW-1:0]   dmem_addr_o,
	output reg  [7:0]       dmem_wdata_o,
	output reg              dmem_re_o,
	output reg              dmem_we_o,
	input  wire [7:0]       dmem_rdata_i,
	output wire [7:0]       flags_o,
	output reg              busy_o
);
`include "fls_defines.vh"

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_EXEC = 2'h1;
	localparam [1:0] ST_MEM  = 2'h2;
	localparam [ADR_W-1:0] GPR_BASE = `FLS_GPR_BASE;
	localparam [ADR_W-1:0] GPR_MASK = `FLS_GPR_MASK;

	// Byte-lane merge of a bus write into a register
	function [31:0] wb_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  sel;
		integer k;
		begin
			wb_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					wb_merge[8*k +: 8] = new_v[8*k +: 8];
				end
			end
		end
	endfunction

	reg  [1:0]       state_r;
	reg  [1:0]       state_nxt;
	reg  [31:0]      cmd_r;
	reg  [15:0]      operand_r;
	reg              illegal_r;
	reg              illegal_nxt;
	reg  [DAW-1:0]   addr_nxt;
	reg  [7:0]       wdata_nxt;
	reg              re_nxt;
	reg              we_nxt;
	reg              fl_we;
	reg              rb_we;
	reg  [7:0]       rb_data;
	reg              rw_we;
	reg  [3:0]       rw_idx;
	reg  [15:0]      rw_data;
	reg  [31:0]      rdat_nxt;
	reg  [31:0]      cmd_wr;
	reg  [31:0]      opnd_wr;

	wire [5:0]  op    = cmd_r[`FLS_CMD_OP_MSB:`FLS_CMD_OP_LSB];
	wire [4:0]  rd    = cmd_r[`FLS_CMD_RD_MSB:`FLS_CMD_RD_LSB];
	wire [4:0]  rr    = cmd_r[`FLS_CMD_RR_MSB:`FLS_CMD_RR_LSB];
	wire        is_st = op[4];
	wire [1:0]  ptr   = op[3:2];
	wire [1:0]  mode  = op[1:0];
	wire [3:0]  ptr_pair = `FLS_PTR_PAIR_BASE + {2'h0, ptr};

	wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        bus_wr   = bus_req & wb_we_i;
	wire        idle     = (state_r == ST_IDLE);
	wire        hit_cmd  = (wb_adr_i == `FLS_CMD_OFS);
	wire        hit_opnd = (wb_adr_i == `FLS_OPERAND_OFS);
	wire        hit_flag = (wb_adr_i == `FLS_FLAGS_OFS);
	wire        hit_stat = (wb_adr_i == `FLS_STATUS_OFS);
	wire        hit_gpr  = ((wb_adr_i & ~GPR_MASK) == GPR_BASE);
	wire        cmd_go   = bus_wr & idle & hit_cmd & wb_sel_i[0];
	wire        gpr_wr   = bus_wr & idle & hit_gpr & wb_sel_i[0];
	wire        flag_wr  = bus_wr & idle & hit_flag & wb_sel_i[0];

	// Displacement form exists only for the second and third pointer,
	// and only as a load here
	wire        ptr_bad  = (ptr == `FLS_PTR_NONE) |
		((mode == `FLS_MODE_DISP) & (is_st | ptr == `FLS_PTR_FIRST));

	wire [7:0]  rd_b;
	wire [15:0] rd_w;
	wire [4:0]  rd_b_idx = idle ? wb_adr_i[6:2] : rr;
	wire [3:0]  rd_w_idx = (op == `FLS_REGISTER_PAIR_COPY_OP) ?
		rr[4:1] : ptr_pair;

	// Effective address for the memory phase
	wire [15:0] ptr_dec  = rd_w - 16'h0001;
	wire [15:0] ptr_inc  = rd_w + 16'h0001;
	wire [15:0] ptr_disp = rd_w + operand_r;
	reg  [15:0] eff_addr;

	always @* begin
		case (mode)
			`FLS_MODE_PREDEC: eff_addr = ptr_dec;
			`FLS_MODE_DISP:   eff_addr = ptr_disp;
			default:          eff_addr = rd_w;
		endcase
	end

	fls_regfile #(
		.NREG (32),
		.AW   (5)
	) u_regfile (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.rd_b_idx_i  (rd_b_idx),
		.rd_b_o      (rd_b),
		.rd_w_idx_i  (rd_w_idx),
		.rd_w_o      (rd_w),
		.wr_b_we_i   (rb_we | gpr_wr),
		.wr_b_idx_i  (gpr_wr ? wb_adr_i[6:2] : rd),
		.wr_b_data_i (gpr_wr ? wb_dat_i[7:0] : rb_data),
		.wr_w_we_i   (rw_we),
		.wr_w_idx_i  (rw_idx),
		.wr_w_data_i (rw_data)
	);

	fls_flags u_flags (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.bit_we_i  (fl_we),
		.bit_idx_i (op[2:0]),
		.bit_val_i (~op[3]),
		.sw_we_i   (flag_wr),
		.sw_data_i (wb_dat_i[7:0]),
		.flags_o   (flags_o)
	);

	// Execution sequencing
	always @* begin
		state_nxt   = state_r;
		illegal_nxt = illegal_r;
		addr_nxt    = dmem_addr_o;
		wdata_nxt   = dmem_wdata_o;
		re_nxt      = 1'b0;
		we_nxt      = 1'b0;
		fl_we       = 1'b0;
		rb_we       = 1'b0;
		rb_data     = 8'h00;
		rw_we       = 1'b0;
		rw_idx      = rd[4:1];
		rw_data     = 16'h0000;
		case (state_r)
			ST_IDLE: begin
				if (cmd_go) begin
					state_nxt   = ST_EXEC;
					illegal_nxt = 1'b0;
				end
			end
			ST_EXEC: begin
				state_nxt = ST_IDLE;
				if (op[5]) begin
					if (ptr_bad) begin
						illegal_nxt = 1'b1;
					end else begin
						addr_nxt  = eff_addr[DAW-1:0];
						re_nxt    = ~is_st;
						we_nxt    = is_st;
						wdata_nxt = rd_b;
						state_nxt = ST_MEM;
					end
				end else if (op[5:4] == `FLS_FLAG_GROUP) begin
					fl_we = 1'b1;
				end else begin
					case (op)
						`FLS_NOP_OP: begin
						end
						`FLS_REGISTER_COPY_OP: begin
							rb_we   = 1'b1;
							rb_data = rd_b;
						end
						`FLS_REGISTER_PAIR_COPY_OP: begin
							rw_we   = 1'b1;
							rw_data = rd_w;
						end
						`FLS_IMMEDIATE_LOAD_OP: begin
							rb_we   = 1'b1;
							rb_data = operand_r[7:0];
						end
						`FLS_DIRECT_DATA_LOAD_OP: begin
							addr_nxt  = operand_r[DAW-1:0];
							re_nxt    = 1'b1;
							state_nxt = ST_MEM;
						end
						default: begin
							illegal_nxt = 1'b1;
						end
					endcase
				end
			end
			ST_MEM: begin
				state_nxt = ST_IDLE;
				if (!(op[5] && is_st)) begin
					rb_we   = 1'b1;
					rb_data = dmem_rdata_i;
				end
				if (op[5]) begin
					rw_idx = ptr_pair;
					if (mode == `FLS_MODE_POSTINC) begin
						rw_we   = 1'b1;
						rw_data = ptr_inc;
					end else if (mode == `FLS_MODE_PREDEC) begin
						rw_we   = 1'b1;
						rw_data = ptr_dec;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Register read mux; GPR window reads as zero while busy
	always @* begin
		rdat_nxt = 32'h00000000;
		if (hit_cmd) begin
			rdat_nxt = cmd_r;
		end else if (hit_opnd) begin
			rdat_nxt = {16'h0000, operand_r};
		end else if (hit_flag) begin
			rdat_nxt = {24'h000000, flags_o};
		end else if (hit_stat) begin
			rdat_nxt[`FLS_STAT_BUSY]    = ~idle;
			rdat_nxt[`FLS_STAT_ILLEGAL] = illegal_r;
		end else if (hit_gpr && idle) begin
			rdat_nxt = {24'h000000, rd_b};
		end
	end

	always @* begin
		cmd_wr  = wb_merge(cmd_r, wb_dat_i, wb_sel_i);
		opnd_wr = wb_merge({16'h0000, operand_r}, wb_dat_i, wb_sel_i);
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r      <= ST_IDLE;
			cmd_r        <= 32'h00000000;
			operand_r    <= 16'h0000;
			illegal_r    <= 1'b0;
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h00000000;
			dmem_addr_o  <= {DAW{1'b0}};
			dmem_wdata_o <= 8'h00;
			dmem_re_o    <= 1'b0;
			dmem_we_o    <= 1'b0;
			busy_o       <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			illegal_r    <= illegal_nxt;
			dmem_addr_o  <= addr_nxt;
			dmem_wdata_o <= wdata_nxt;
			dmem_re_o    <= re_nxt;
			dmem_we_o    <= we_nxt;
			busy_o       <= (state_nxt != ST_IDLE);
			wb_ack_o     <= bus_req;
			if (bus_req) begin
				wb_dat_o <= wb_we_i ? 32'h00000000 : rdat_nxt;
			end
			if (bus_wr && idle && hit_cmd) begin
				cmd_r <= cmd_wr & 32'h001F1F3F;
			end
			if (bus_wr && idle && hit_opnd) begin
				operand_r <= opnd_wr[15:0];
			end
		end
	end

endmodule // fls_exec
`default_nettype wire

// *** test/fls_exec_props.sv ***
// Checker for the executor's bus, memory and flag timing
`default_nettype none
module fls_exec_props (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       dmem_re_o,
	input wire logic       dmem_we_o,
	input wire logic [7:0] flags_o,
	input wire logic       busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire mem_op = dmem_re_o | dmem_we_o;
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_flag_single: assert property (
		$changed(flags_o) && !wb_ack_o
		|-> $onehot(flags_o ^ $past(flags_o))) else $error("flags");
	a_flags_memop: assert property (
		mem_op |-> $stable(flags_o) ##1 $stable(flags_o))
		else $error("flags moved");
	a_mem_late: assert property (
		mem_op |-> $past(busy_o) && busy_o ##1 !busy_o)
		else $error("memory op timing");
	a_busy_short: assert property (
		$rose(busy_o) |=> ##[0:1] !busy_o) else $error("busy long");
	a_re_pulse: assert property (dmem_re_o |=> !dmem_re_o)
		else $error("read pulse");
	a_we_pulse: assert property (dmem_we_o |=> !mem_op)
		else $error("write pulse");
	a_rw_excl: assert property (!(dmem_re_o && dmem_we_o))
		else $error("read and write");
	c_read: cover property (dmem_re_o);
	c_write: cover property (dmem_we_o);
	c_flag: cover property ($changed(flags_o) && !wb_ack_o);
endmodule // fls_exec_props
bind fls_exec fls_exec_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.dmem_re_o(dmem_re_o), .dmem_we_o(dmem_we_o), .flags_o(flags_o),
	.busy_o(busy_o));
`default_nettype wire

// *** test/fls_dmem_model.sv ***
// Data memory partner: combinational read, write at clock edge
`default_nettype none
module fls_dmem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        re_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:255];
	logic [7:0]  junk = 8'h00;
	logic [15:0] la   = 16'h0000;
	int          cnt  = 0;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
	// Unselected: a changing pattern, not the last byte
	assign rdata_o = re_i ? mem[addr_i[7:0]] : junk;
	always @(posedge clk_i) begin
		junk <= junk + 8'h3B;
		if (re_i || we_i) begin
			la <= addr_i;
			cnt <= cnt + 1;
		end
		if (we_i) mem[addr_i[7:0]] <= wdata_i;
	end
endmodule // fls_dmem_model
`default_nettype wire

// *** test/tb_flag_and_load_store_exec.sv ***
// Self-checking bench for the flag and load/store executor
`default_nettype none
`include "fls_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t %h %h", $time, g, e); end end
module tb_flag_and_load_store_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0]  adr = 0, mw, mr, fl, e, t;
	logic [3:0]  sel = 0;
	logic [31:0] wd = 0, rdat, q;
	logic        ack, re, wen, busy, ill;
	logic [15:0] ma, pt, ea;
	int          error_cnt = 0, checks = 0, b, v, p, m, s, c0;
	always #2 clk_i = ~clk_i;
	fls_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dmem_addr_o(ma), .dmem_wdata_o(mw), .dmem_re_o(re),
		.dmem_we_o(wen), .dmem_rdata_i(mr), .flags_o(fl),
		.busy_o(busy));
	fls_dmem_model mem (.clk_i(clk_i), .addr_i(ma), .re_i(re),
		.we_i(wen), .wdata_i(mw), .rdata_o(mr));
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task automatic gr(input int i);
		bus(0, 8'(128 + 4 * i), 0);
	endtask
	task automatic gw(input int i, input logic [7:0] d);
		bus(1, 8'(128 + 4 * i), {24'h0, d});
	endtask
	// Busy in the second cycle only for memory ops
	task automatic ex(input logic [5:0] o, input int d, r,
		input logic [15:0] k, input logic mm);
		bus(1, `FLS_OPERAND_OFS, {16'h0, k});
		bus(1, `FLS_CMD_OFS, {11'h0, 5'(r), 3'h0, 5'(d), 2'h0, o});
		`CHK(busy, mm)
		@(posedge clk_i);
		`CHK(busy, 1'b0)
	endtask
	task automatic summarize;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		`CHK(fl, `FLS_FLAGS_RST)
		for (b = 0; b < 8; b++)
			for (v = 0; v < 2; v++) begin
				e = v ? 8'h00 : 8'hFF;
				bus(1, `FLS_FLAGS_OFS, {24'h0, e});
				e[b] = 1'(v);
				ex({2'h1, 1'(!v), 3'(b)}, 0, 0, 0, 0);
				`CHK(fl, e)
			end
		$display("test flag ops done");
		bus(1, `FLS_FLAGS_OFS, 32'hC3);
		for (s = 0; s < 2; s++)
			for (p = 0; p < 3; p++)
				for (m = 0; m < 4; m++) begin
					pt = (m == 2) ? 16'h0100 : 16'h00FF;
					ea = (m == 3) ? 16'h0102 : 16'h00FF;
					ill = (m == 3) && (p == 0 || s == 1);
					gw(26 + 2 * p, pt[7:0]);
					gw(27 + 2 * p, pt[15:8]);
					gw(5, 8'h9C);
					c0 = mem.cnt;
					ex({1'b1, 1'(s), 2'(p), 2'(m)}, 3, 5, 16'h0003, !ill);
					`CHK(fl, 8'hC3)
					if (ill) begin
						bus(0, `FLS_STATUS_OFS, 0);
						`CHK(q[1], 1'b1)
						`CHK(mem.cnt, c0)
					end else begin
						`CHK(mem.la, ea)
						if (s) begin
							`CHK(mem.mem[ea[7:0]], 8'h9C)
						end else begin
							gr(3);
							`CHK(q[7:0], ea[7:0] ^ 8'h5A)
						end
						gr(26 + 2 * p);
						t = q[7:0];
						gr(27 + 2 * p);
						pt = (m == 1) ? 16'h0100 : 16'h00FF;
						`CHK({q[7:0], t}, pt)
					end
				end
		$display("test pointer ops done");
		ex(`FLS_DIRECT_DATA_LOAD_OP, 4, 0, 16'h0077, 1);
		`CHK(mem.la, 16'h0077)
		gr(4);
		`CHK(q[7:0], 8'h77 ^ 8'h5A)
		bus(0, `FLS_STATUS_OFS, 0);
		`CHK(q[1:0], 2'h0)
		ex(`FLS_REGISTER_COPY_OP, 6, 5, 0, 0);
		gr(6);
		`CHK(q[7:0], 8'h9C)
		gw(27, 8'h4D);
		ex(`FLS_REGISTER_PAIR_COPY_OP, 8, 26, 0, 0);
		gr(8);
		`CHK(q[7:0], 8'hFF)
		gr(9);
		`CHK(q[7:0], 8'h4D)
		ex(`FLS_IMMEDIATE_LOAD_OP, 10, 0, 16'h00E7, 0);
		gr(10);
		`CHK(q[7:0], 8'hE7)
		`CHK(fl, 8'hC3)
		bus(0, 8'h40, 32'h0);
		`CHK(q, 32'h0)
		ex(`FLS_NOP_OP, 0, 0, 0, 0);
		`CHK(fl, 8'hC3)
		ex(6'h05, 0, 0, 0, 0);
		bus(0, `FLS_STATUS_OFS, 0);
		`CHK(q[1:0], 2'h2)
		c0 = mem.cnt;
		ex(6'h2C, 3, 5, 0, 0);
		bus(0, `FLS_STATUS_OFS, 0);
		`CHK(q[1:0], 2'h2)
		`CHK(mem.cnt, c0)
		`CHK(fl, 8'hC3)
		$display("test moves done");
		summarize();
	end
endmodule // tb_flag_and_load_store_exec
`default_nettype wire
